// File: verilog/rac_pkg.sv
/*
 * rac_pkg: shared constants of the register-access bank: address map,
 * word offsets, per-bit access attribute masks and values after reset.
 * Assumes a 32-bit data word and a 9-bit byte address.
 */
package rac_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;

   // ---------------------------------------------------------------
   // address map
   // ---------------------------------------------------------------
   localparam logic [8:0] SYS_REGION_LO = 9'h000;
   localparam logic [8:0] SYS_REGION_HI = 9'h0FF;
   localparam logic [8:0] MAC_REGION_LO = 9'h100;
   localparam logic [8:0] MAC_REGION_HI = 9'h1FC;

   typedef enum logic [1:0] {
      RAC_REGION_NONE,
      RAC_REGION_SYS,
      RAC_REGION_MAC
   } rac_region_t;

   // ---------------------------------------------------------------
   // word offsets
   // ---------------------------------------------------------------
   localparam logic [8:0] SYS_STATUS_OFS = 9'h000;
   localparam logic [8:0] SYS_CTRL_OFS   = 9'h004;
   localparam logic [8:0] SYS_EVENT_OFS  = 9'h008;
   localparam logic [8:0] MAC_CTRL_OFS   = 9'h100;
   localparam logic [8:0] MAC_STATUS_OFS = 9'h104;

   // ---------------------------------------------------------------
   // system status word: ro, clear-on-read, latch high/low, sticky
   // ---------------------------------------------------------------
   localparam logic [31:0] SYS_STATUS_RO    = 32'h0000_00FF;
   localparam logic [31:0] SYS_STATUS_RC    = 32'h0000_0F00;
   localparam logic [31:0] SYS_STATUS_LH    = 32'h0000_F000;
   localparam logic [31:0] SYS_STATUS_LL    = 32'h000F_0000;
   localparam logic [31:0] SYS_STATUS_STKY  = 32'h00F0_0000;
   localparam logic [31:0] SYS_STATUS_RSVD  = 32'hFF00_0000;
   localparam logic [31:0] SYS_STATUS_RST   = 32'h000F_0000;

   // ---------------------------------------------------------------
   // system control word: rw, immune rw, self-clear, set-on-read, wo
   // ---------------------------------------------------------------
   localparam logic [31:0] SYS_CTRL_SOFT_RESET_IMMUNE_ATTR    = 32'h0000_00FF;
   localparam logic [31:0] SYS_CTRL_SC      = 32'h0000_1000;
   localparam logic [31:0] SYS_CTRL_RS      = 32'h0000_2000;
   localparam logic [31:0] SYS_CTRL_WO      = 32'h00FF_0000;
   localparam logic [31:0] SYS_CTRL_RSVD    = 32'hFF00_C000;
   localparam logic [31:0] SYS_CTRL_RST     = 32'h0000_0000;

   // ---------------------------------------------------------------
   // system event word: write-one-clear, write-anything-clear
   // ---------------------------------------------------------------
   localparam logic [31:0] SYS_EVENT_WC     = 32'h0000_FFFF;
   localparam logic [31:0] SYS_EVENT_WAC    = 32'h00FF_0000;
   localparam logic [31:0] SYS_EVENT_RSVD   = 32'hFF00_0000;
   localparam logic [31:0] SYS_EVENT_RST    = 32'h0000_0000;

   // ---------------------------------------------------------------
   // mac control and status words
   // ---------------------------------------------------------------
   localparam logic [31:0] MAC_CTRL_SOFT_RESET_IMMUNE_ATTR    = 32'h0000_FF00;
   localparam logic [31:0] MAC_CTRL_SC      = 32'h0001_0000;
   localparam logic [31:0] MAC_CTRL_RSVD    = 32'hFFFE_0000;
   localparam logic [31:0] MAC_CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] MAC_STATUS_WC    = 32'h0000_FFFF;
   localparam logic [31:0] MAC_STATUS_STKY  = 32'h000F_0000;
   localparam logic [31:0] MAC_STATUS_RSVD  = 32'hFFF0_0000;
   localparam logic [31:0] MAC_STATUS_RST   = 32'h0000_0000;

   localparam logic [31:0] NO_BITS          = 32'h0000_0000;

endpackage : rac_pkg

// File: verilog/rac_word.sv
/*
 * rac_word: one 32-bit register word whose bits each follow an access
 * attribute chosen by parameter masks.
 * Assumes rd and wr are one-cycle strobes, never both high, on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module rac_word #(
   parameter logic [31:0] RESET_VAL = 32'h0000_0000,
   parameter logic [31:0] RO_MASK   = 32'h0000_0000,
   parameter logic [31:0] RS_MASK   = 32'h0000_0000,
   parameter logic [31:0] WO_MASK   = 32'h0000_0000,
   parameter logic [31:0] WC_MASK   = 32'h0000_0000,
   parameter logic [31:0] WAC_MASK  = 32'h0000_0000,
   parameter logic [31:0] RC_MASK   = 32'h0000_0000,
   parameter logic [31:0] LL_MASK   = 32'h0000_0000,
   parameter logic [31:0] LH_MASK   = 32'h0000_0000,
   parameter logic [31:0] SC_MASK   = 32'h0000_0000,
   parameter logic [31:0] STKY_MASK = 32'h0000_0000,
   parameter logic [31:0] SOFT_RESET_IMMUNE_ATTR_MASK = 32'h0000_0000,
   parameter logic [31:0] RSVD_MASK = 32'h0000_0000
) (
   // clock and resets
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        soft_rst,
   // access strobes
   input  wire logic        rd,
   input  wire logic        wr,
   input  wire logic [31:0] wdata,
   // hardware side
   input  wire logic [31:0] hw_set,
   input  wire logic [31:0] hw_val,
   // results
   output logic      [31:0] q,
   output logic      [31:0] rdata
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [31:0] bits;
      logic [31:0] armed;   // sticky bit read while its cause stood
   } rac_word_state_t;

   rac_word_state_t state;
   rac_word_state_t next_state;

   // per-bit next value by attribute
   always_comb begin
      next_state = state;
      for (int i = 0; i < 32; i++) begin
         if (RSVD_MASK[i]) begin
            next_state.bits[i] = 1'b0;
         end else if (RO_MASK[i]) begin
            next_state.bits[i] = hw_val[i];
         end else if (RC_MASK[i]) begin
            if (hw_set[i]) begin
               next_state.bits[i] = 1'b1;
            end else if (rd) begin
               next_state.bits[i] = 1'b0;
            end
         end else if (LH_MASK[i]) begin
            if (hw_set[i]) begin
               next_state.bits[i] = 1'b1;
            end else if (rd) begin
               next_state.bits[i] = 1'b0;
            end
         end else if (LL_MASK[i]) begin
            if (!hw_val[i]) begin
               next_state.bits[i] = 1'b0;
            end else if (rd) begin
               next_state.bits[i] = 1'b1;
            end
         end else if (STKY_MASK[i]) begin
            if (hw_val[i]) begin
               next_state.bits[i] = 1'b1;
               if (rd && state.bits[i]) begin
                  next_state.armed[i] = 1'b1;
               end
            end else if (rd || state.armed[i]) begin
               next_state.bits[i]  = 1'b0;
               next_state.armed[i] = 1'b0;
            end
         end else if (WC_MASK[i]) begin
            if (hw_set[i]) begin
               next_state.bits[i] = 1'b1;
            end else if (wr && wdata[i]) begin
               next_state.bits[i] = 1'b0;
            end
         end else if (WAC_MASK[i]) begin
            if (hw_set[i]) begin
               next_state.bits[i] = 1'b1;
            end else if (wr) begin
               next_state.bits[i] = 1'b0;
            end
         end else if (SC_MASK[i]) begin
            if (wr && wdata[i]) begin
               next_state.bits[i] = 1'b1;
            end else begin
               next_state.bits[i] = 1'b0;
            end
         end else if (RS_MASK[i]) begin
            if (rd) begin
               next_state.bits[i] = 1'b1;
            end else if (wr) begin
               next_state.bits[i] = wdata[i];
            end
         end else if (wr) begin
            next_state.bits[i] = wdata[i];
         end
      end
      if (soft_rst) begin
         next_state.bits  = (next_state.bits & SOFT_RESET_IMMUNE_ATTR_MASK) | (RESET_VAL & ~SOFT_RESET_IMMUNE_ATTR_MASK);
         next_state.armed = next_state.armed & SOFT_RESET_IMMUNE_ATTR_MASK;
      end
   end

   // state register, hardware reset only
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '{bits: RESET_VAL, armed: 32'h0000_0000};
      end else begin
         state <= next_state;
      end
   end

   // outputs
   assign q = state.bits;
   assign rdata = state.bits & ~(WO_MASK | RSVD_MASK);

endmodule : rac_word

`default_nettype wire

// File: verilog/rac_bank.sv
/*
 * rac_bank: register bank with per-bit access attributes and the
 * top-level decode into the system and mac regions.
 * Assumes all inputs come from logic on REF_CLK; one access per request.
 */
`timescale 1ns/1ps
`default_nettype none

module rac_bank (
   // clock and resets
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        SOFT_RST,
   // access port
   input  wire logic        ACC_REQ,
   input  wire logic        ACC_WR,
   input  wire logic [8:0]  ACC_ADDR,
   input  wire logic [31:0] ACC_WDATA,
   output logic             ACC_ACK,
   output logic      [31:0] ACC_RDATA,
   // hardware status sources
   input  wire logic [31:0] SYS_STAT_VAL,
   input  wire logic [31:0] SYS_STAT_SET,
   input  wire logic [31:0] SYS_EVT_SET,
   input  wire logic [31:0] MAC_STAT_VAL,
   input  wire logic [31:0] MAC_STAT_SET,
   // control outputs
   output logic      [31:0] SYS_CTRL_Q,
   output logic      [31:0] MAC_CTRL_Q
);

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // region of a byte address
   function automatic rac_pkg::rac_region_t region_of(input logic [8:0] a);
      if (a >= rac_pkg::SYS_REGION_LO && a <= rac_pkg::SYS_REGION_HI) begin
         return rac_pkg::RAC_REGION_SYS;
      end else if (a >= rac_pkg::MAC_REGION_LO && a <= rac_pkg::MAC_REGION_HI) begin
         return rac_pkg::RAC_REGION_MAC;
      end else begin
         return rac_pkg::RAC_REGION_NONE;
      end
   endfunction : region_of

   // word hit: right region and aligned offset match
   function automatic logic word_hit(input logic [8:0] a, input logic [8:0] ofs,
                                     input rac_pkg::rac_region_t rg);
      return (region_of(a) == rg) && (a == ofs);
   endfunction : word_hit

   // ---------------------------------------------------------------
   // strobes
   // ---------------------------------------------------------------
   logic        acc_rd;
   logic        acc_wr;
   logic        hit_sys_status;
   logic        hit_sys_ctrl;
   logic        hit_sys_event;
   logic        hit_mac_ctrl;
   logic        hit_mac_status;
   logic [31:0] rd_sys_status;
   logic [31:0] rd_sys_ctrl;
   logic [31:0] rd_sys_event;
   logic [31:0] rd_mac_ctrl;
   logic [31:0] rd_mac_status;
   logic [31:0] mac_ctrl_q;
   logic [31:0] sys_ctrl_q;

   // request split and word selects
   assign acc_rd         = ACC_REQ & ~ACC_WR;
   assign acc_wr         = ACC_REQ & ACC_WR;
   assign hit_sys_status = word_hit(ACC_ADDR, rac_pkg::SYS_STATUS_OFS, rac_pkg::RAC_REGION_SYS);
   assign hit_sys_ctrl   = word_hit(ACC_ADDR, rac_pkg::SYS_CTRL_OFS, rac_pkg::RAC_REGION_SYS);
   assign hit_sys_event  = word_hit(ACC_ADDR, rac_pkg::SYS_EVENT_OFS, rac_pkg::RAC_REGION_SYS);
   assign hit_mac_ctrl   = word_hit(ACC_ADDR, rac_pkg::MAC_CTRL_OFS, rac_pkg::RAC_REGION_MAC);
   assign hit_mac_status = word_hit(ACC_ADDR, rac_pkg::MAC_STATUS_OFS, rac_pkg::RAC_REGION_MAC);

   // ---------------------------------------------------------------
   // register words
   // ---------------------------------------------------------------
   // system status: ro, clear-on-read, latches, sticky
   rac_word #(
      .RESET_VAL (rac_pkg::SYS_STATUS_RST),
      .RO_MASK   (rac_pkg::SYS_STATUS_RO),
      .RC_MASK   (rac_pkg::SYS_STATUS_RC),
      .LH_MASK   (rac_pkg::SYS_STATUS_LH),
      .LL_MASK   (rac_pkg::SYS_STATUS_LL),
      .STKY_MASK (rac_pkg::SYS_STATUS_STKY),
      .RSVD_MASK (rac_pkg::SYS_STATUS_RSVD)
   ) u_sys_status (
      .clk      (REF_CLK),
      .rst      (RST),
      .soft_rst (SOFT_RST),
      .rd       (acc_rd & hit_sys_status),
      .wr       (acc_wr & hit_sys_status),
      .wdata    (ACC_WDATA),
      .hw_set   (SYS_STAT_SET),
      .hw_val   (SYS_STAT_VAL),
      .q        (),
      .rdata    (rd_sys_status)
   );

   // system control: rw, immune, self-clear, set-on-read, write-only
   rac_word #(
      .RESET_VAL (rac_pkg::SYS_CTRL_RST),
      .SOFT_RESET_IMMUNE_ATTR_MASK (rac_pkg::SYS_CTRL_SOFT_RESET_IMMUNE_ATTR),
      .SC_MASK   (rac_pkg::SYS_CTRL_SC),
      .RS_MASK   (rac_pkg::SYS_CTRL_RS),
      .WO_MASK   (rac_pkg::SYS_CTRL_WO),
      .RSVD_MASK (rac_pkg::SYS_CTRL_RSVD)
   ) u_sys_ctrl (
      .clk      (REF_CLK),
      .rst      (RST),
      .soft_rst (SOFT_RST),
      .rd       (acc_rd & hit_sys_ctrl),
      .wr       (acc_wr & hit_sys_ctrl),
      .wdata    (ACC_WDATA),
      .hw_set   (rac_pkg::NO_BITS),
      .hw_val   (rac_pkg::NO_BITS),
      .q        (sys_ctrl_q),
      .rdata    (rd_sys_ctrl)
   );

   // system events: write-one-clear, write-any-clear
   rac_word #(
      .RESET_VAL (rac_pkg::SYS_EVENT_RST),
      .WC_MASK   (rac_pkg::SYS_EVENT_WC),
      .WAC_MASK  (rac_pkg::SYS_EVENT_WAC),
      .RSVD_MASK (rac_pkg::SYS_EVENT_RSVD)
   ) u_sys_event (
      .clk      (REF_CLK),
      .rst      (RST),
      .soft_rst (SOFT_RST),
      .rd       (acc_rd & hit_sys_event),
      .wr       (acc_wr & hit_sys_event),
      .wdata    (ACC_WDATA),
      .hw_set   (SYS_EVT_SET),
      .hw_val   (rac_pkg::NO_BITS),
      .q        (),
      .rdata    (rd_sys_event)
   );

   // mac control: rw, immune bits 15:8, self-clear
   rac_word #(
      .RESET_VAL (rac_pkg::MAC_CTRL_RST),
      .SOFT_RESET_IMMUNE_ATTR_MASK (rac_pkg::MAC_CTRL_SOFT_RESET_IMMUNE_ATTR),
      .SC_MASK   (rac_pkg::MAC_CTRL_SC),
      .RSVD_MASK (rac_pkg::MAC_CTRL_RSVD)
   ) u_mac_ctrl (
      .clk      (REF_CLK),
      .rst      (RST),
      .soft_rst (SOFT_RST),
      .rd       (acc_rd & hit_mac_ctrl),
      .wr       (acc_wr & hit_mac_ctrl),
      .wdata    (ACC_WDATA),
      .hw_set   (rac_pkg::NO_BITS),
      .hw_val   (rac_pkg::NO_BITS),
      .q        (mac_ctrl_q),
      .rdata    (rd_mac_ctrl)
   );

   // mac status: write-one-clear, sticky
   rac_word #(
      .RESET_VAL (rac_pkg::MAC_STATUS_RST),
      .WC_MASK   (rac_pkg::MAC_STATUS_WC),
      .STKY_MASK (rac_pkg::MAC_STATUS_STKY),
      .RSVD_MASK (rac_pkg::MAC_STATUS_RSVD)
   ) u_mac_status (
      .clk      (REF_CLK),
      .rst      (RST),
      .soft_rst (SOFT_RST),
      .rd       (acc_rd & hit_mac_status),
      .wr       (acc_wr & hit_mac_status),
      .wdata    (ACC_WDATA),
      .hw_set   (MAC_STAT_SET),
      .hw_val   (MAC_STAT_VAL),
      .q        (),
      .rdata    (rd_mac_status)
   );

   // ---------------------------------------------------------------
   // answer path
   // ---------------------------------------------------------------
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
      logic [31:0] sys_ctrl;
      logic [31:0] mac_ctrl;
   } rac_bank_state_t;

   rac_bank_state_t state;
   rac_bank_state_t next_state;

   // read mux and acknowledge
   always_comb begin
      next_state          = state;
      next_state.ack      = ACC_REQ;
      next_state.sys_ctrl = sys_ctrl_q;
      next_state.mac_ctrl = mac_ctrl_q;
      if (acc_rd) begin
         unique case (1'b1)
            hit_sys_status: next_state.rdata = rd_sys_status;
            hit_sys_ctrl:   next_state.rdata = rd_sys_ctrl;
            hit_sys_event:  next_state.rdata = rd_sys_event;
            hit_mac_ctrl:   next_state.rdata = rd_mac_ctrl;
            hit_mac_status: next_state.rdata = rd_mac_status;
            default:        next_state.rdata = 32'h0000_0000;
         endcase
      end
   end

   // answer register
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state <= '{ack: 1'b0, rdata: 32'h0000_0000,
                    sys_ctrl: rac_pkg::SYS_CTRL_RST, mac_ctrl: rac_pkg::MAC_CTRL_RST};
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from flops
   assign ACC_ACK    = state.ack;
   assign ACC_RDATA  = state.rdata;
   assign SYS_CTRL_Q = state.sys_ctrl;
   assign MAC_CTRL_Q = state.mac_ctrl;

endmodule : rac_bank

`default_nettype wire

// File: dv/rac_bank_sva.sv
/*
 * rac_bank_sva: port-level checks of the register bank.
 * Assumes it is bound to rac_bank and sees only its ports on REF_CLK.
 */
`timescale 1ns/1ps
`default_nettype none

module rac_bank_sva (
   // clock and resets
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic        SOFT_RST,
   // access port
   input wire logic        ACC_REQ,
   input wire logic        ACC_WR,
   input wire logic [8:0]  ACC_ADDR,
   input wire logic [31:0] ACC_WDATA,
   input wire logic        ACC_ACK,
   input wire logic [31:0] ACC_RDATA,
   // hardware side and outputs
   input wire logic [31:0] SYS_STAT_VAL,
   input wire logic [31:0] SYS_STAT_SET,
   input wire logic [31:0] SYS_CTRL_Q
);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   logic rd;
   logic rd_stat;
   logic rd_ctrl;
   logic hit;

   // read strobes and mapped-word hit
   assign rd      = ACC_REQ && !ACC_WR;
   assign rd_stat = rd && ACC_ADDR == rac_pkg::SYS_STATUS_OFS && !SOFT_RST;
   assign rd_ctrl = rd && ACC_ADDR == rac_pkg::SYS_CTRL_OFS && !SOFT_RST;
   assign hit     = ACC_ADDR inside {rac_pkg::SYS_STATUS_OFS, rac_pkg::SYS_CTRL_OFS,
                                     rac_pkg::SYS_EVENT_OFS, rac_pkg::MAC_CTRL_OFS, rac_pkg::MAC_STATUS_OFS};

   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);

   // two status reads on consecutive edges, no new sets of bits 15:8 on the first
   sequence s_rd_twice;
      (rd_stat && SYS_STAT_SET[15:8] == 8'h00) ##1 rd_stat;
   endsequence

   // one cycle high, then low
   sequence s_pulse(b);
      b ##1 !b;
   endsequence

   a_ack_after_req: assert property (ACC_REQ |=> ACC_ACK)
      else $error("no acknowledge one cycle after a request");
   a_unmapped_zero: assert property (rd && !hit |=> ACC_RDATA == 32'h0000_0000)
      else $error("unmapped read returned nonzero data");
   a_ro_follows_hw: assert property (
      rd_stat && !$past(SOFT_RST) |=> ACC_RDATA[7:0] == $past(SYS_STAT_VAL[7:0], 2))
      else $error("read-only field does not follow its source");
   a_read_sets_bit: assert property (rd_ctrl |=> ##1 SYS_CTRL_Q[13])
      else $error("read did not set the set-on-read bit");
   a_self_clear_pulse: assert property (
      ACC_REQ && ACC_WR && !SOFT_RST && ACC_ADDR == rac_pkg::SYS_CTRL_OFS && ACC_WDATA[12]
      |=> ##1 s_pulse(SYS_CTRL_Q[12]))
      else $error("self-clearing bit not a single cycle pulse");
   a_immune_hold: assert property (
      SOFT_RST && !(ACC_REQ && ACC_WR) |=> ##1 $stable(SYS_CTRL_Q[7:0]))
      else $error("immune bits changed on soft reset");
   a_soft_clears: assert property (
      SOFT_RST |=> ##1 (SYS_CTRL_Q & ~(rac_pkg::SYS_CTRL_SOFT_RESET_IMMUNE_ATTR | rac_pkg::SYS_CTRL_RSVD)) == 32'h0000_0000)
      else $error("soft reset left non-immune bits set");
   a_read_clears: assert property (s_rd_twice |=> ACC_RDATA[15:8] == 8'h00)
      else $error("clear-on-read or latch bits survived a read");

endmodule : rac_bank_sva

bind rac_bank rac_bank_sva rac_bank_sva_i (.REF_CLK(REF_CLK), .RST(RST), .SOFT_RST(SOFT_RST),
   .ACC_REQ(ACC_REQ), .ACC_WR(ACC_WR), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA), .ACC_ACK(ACC_ACK),
   .ACC_RDATA(ACC_RDATA), .SYS_STAT_VAL(SYS_STAT_VAL), .SYS_STAT_SET(SYS_STAT_SET), .SYS_CTRL_Q(SYS_CTRL_Q));

`default_nettype wire

// File: dv/tb.sv
/*
 * tb: self-checking bench of the register bank, one task per scenario.
 * Assumes rac_bank and its checker are compiled alongside.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic        REF_CLK;
   logic        RST;
   logic        SOFT_RST;
   logic        ACC_REQ;
   logic        ACC_WR;
   logic [8:0]  ACC_ADDR;
   logic [31:0] ACC_WDATA;
   logic        ACC_ACK;
   logic [31:0] ACC_RDATA;
   logic [31:0] SYS_STAT_VAL;
   logic [31:0] SYS_STAT_SET;
   logic [31:0] SYS_EVT_SET;
   logic [31:0] MAC_STAT_VAL;
   logic [31:0] MAC_STAT_SET;
   logic [31:0] SYS_CTRL_Q;
   logic [31:0] MAC_CTRL_Q;
   int          fail_count = 0;
   int          checks_done = 0;
   int          cycles = 0;

   rac_bank rac_bank_i (.REF_CLK(REF_CLK), .RST(RST), .SOFT_RST(SOFT_RST), .ACC_REQ(ACC_REQ),
      .ACC_WR(ACC_WR), .ACC_ADDR(ACC_ADDR), .ACC_WDATA(ACC_WDATA), .ACC_ACK(ACC_ACK),
      .ACC_RDATA(ACC_RDATA), .SYS_STAT_VAL(SYS_STAT_VAL), .SYS_STAT_SET(SYS_STAT_SET),
      .SYS_EVT_SET(SYS_EVT_SET), .MAC_STAT_VAL(MAC_STAT_VAL), .MAC_STAT_SET(MAC_STAT_SET),
      .SYS_CTRL_Q(SYS_CTRL_Q), .MAC_CTRL_Q(MAC_CTRL_Q));

   // 100 MHz clock
   initial begin
      REF_CLK = 1'b0;
      forever #5 REF_CLK = ~REF_CLK;
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   // only the bits set in mask take part in the compare
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] mask);
      checks_done++;
      if ((seen & mask) !== (exp & mask)) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // one access, request held for one edge, answer read mid-cycle
   task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge REF_CLK);
      ACC_REQ   <= 1'b1;
      ACC_WR    <= w;
      ACC_ADDR  <= a;
      ACC_WDATA <= d;
      @(posedge REF_CLK);
      ACC_REQ <= 1'b0;
      @(negedge REF_CLK);
      check({31'h0000_0000, ACC_ACK}, 32'h0000_0001, 32'h0000_0001);
      r = ACC_RDATA;
   endtask : acc

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   // map edges and unmapped places
   task automatic t_map;
      logic [31:0] r;
      logic [8:0]  bad [7] = '{9'h005, 9'h00C, 9'h0FC, 9'h0FF, 9'h1FC, 9'h1FD, 9'h1FF};
      acc(1'b1, rac_pkg::SYS_CTRL_OFS, 32'h0000_0055, r);
      acc(1'b1, rac_pkg::MAC_CTRL_OFS, 32'h0000_AA00, r);
      acc(1'b0, rac_pkg::SYS_CTRL_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_0055, rac_pkg::SYS_CTRL_SOFT_RESET_IMMUNE_ATTR);
      acc(1'b0, rac_pkg::MAC_CTRL_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_AA00, rac_pkg::MAC_CTRL_SOFT_RESET_IMMUNE_ATTR);
      foreach (bad[i]) begin
         acc(1'b1, bad[i], 32'hFFFF_FFFF, r);
         acc(1'b0, bad[i], 32'h0000_0000, r);
         check(r, 32'h0000_0000, 32'hFFFF_FFFF);
      end
      check(SYS_CTRL_Q, 32'h0000_2055, ~rac_pkg::SYS_CTRL_RSVD);
      check(MAC_CTRL_Q, 32'h0000_AA00, ~rac_pkg::MAC_CTRL_RSVD);
   endtask : t_map

   // read-only field ignores a write with zero reserved bits
   task automatic t_ro;
      logic [31:0] r;
      @(posedge REF_CLK);
      SYS_STAT_VAL <= 32'h000F_00A5;
      acc(1'b1, rac_pkg::SYS_STATUS_OFS, 32'h00FF_FF5A, r);
      acc(1'b0, rac_pkg::SYS_STATUS_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_00A5, rac_pkg::SYS_STATUS_RO);
   endtask : t_ro

   // read returns old value, then the bit is set
   task automatic t_rs;
      logic [31:0] r;
      acc(1'b1, rac_pkg::SYS_CTRL_OFS, 32'h0000_0055, r);
      acc(1'b0, rac_pkg::SYS_CTRL_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_0000, rac_pkg::SYS_CTRL_RS);
      acc(1'b0, rac_pkg::SYS_CTRL_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_2000, rac_pkg::SYS_CTRL_RS);
   endtask : t_rs

   task automatic t_evt;
      logic [31:0] r;
      @(posedge REF_CLK);
      SYS_EVT_SET <= 32'h00FF_FFFF;
      @(posedge REF_CLK);
      SYS_EVT_SET <= 32'h0000_0000;
      acc(1'b1, rac_pkg::SYS_EVENT_OFS, 32'h0000_00F0, r);
      acc(1'b0, rac_pkg::SYS_EVENT_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_FF0F, ~rac_pkg::SYS_EVENT_RSVD);
      @(posedge REF_CLK);
      SYS_EVT_SET <= 32'h00FF_0000;
      @(posedge REF_CLK);
      SYS_EVT_SET <= 32'h0000_0000;
      acc(1'b1, rac_pkg::SYS_EVENT_OFS, 32'h0000_0000, r);
      acc(1'b0, rac_pkg::SYS_EVENT_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_FF0F, ~rac_pkg::SYS_EVENT_RSVD);
   endtask : t_evt

   task automatic t_rc;
      logic [31:0] r;
      @(posedge REF_CLK);
      SYS_STAT_SET <= 32'h0000_FF00;
      SYS_STAT_VAL <= 32'h0000_00A5;
      @(posedge REF_CLK);
      SYS_STAT_SET <= 32'h0000_0000;
      SYS_STAT_VAL <= 32'h000F_00A5;
      acc(1'b1, rac_pkg::SYS_STATUS_OFS, 32'h0000_0000, r);
      @(posedge REF_CLK);
      ACC_REQ  <= 1'b1;
      ACC_WR   <= 1'b0;
      ACC_ADDR <= rac_pkg::SYS_STATUS_OFS;
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      check(ACC_RDATA, 32'h0000_FF00, 32'h000F_FF00);
      @(posedge REF_CLK);
      ACC_REQ <= 1'b0;
      @(negedge REF_CLK);
      check(ACC_RDATA, 32'h000F_0000, 32'h000F_FF00);
   endtask : t_rc

   // sticky status held until read, mac one-clear bits
   task automatic t_sticky;
      logic [31:0] r;
      logic [3:0]  cause [4] = '{4'h0, 4'hF, 4'hF, 4'h0};
      logic [3:0]  exp   [4] = '{4'h0, 4'hF, 4'hF, 4'h0};
      @(posedge REF_CLK);
      MAC_STAT_VAL <= 32'h000F_0000;
      MAC_STAT_SET <= 32'h0000_00FF;
      @(posedge REF_CLK);
      MAC_STAT_VAL <= 32'h0000_0000;
      MAC_STAT_SET <= 32'h0000_0000;
      acc(1'b1, rac_pkg::MAC_STATUS_OFS, 32'h0000_000F, r);
      acc(1'b0, rac_pkg::MAC_STATUS_OFS, 32'h0000_0000, r);
      check(r, 32'h000F_00F0, rac_pkg::MAC_STATUS_STKY | rac_pkg::MAC_STATUS_WC);
      foreach (cause[i]) begin
         @(posedge REF_CLK);
         MAC_STAT_VAL <= {12'h000, cause[i], 16'h0000};
         acc(1'b0, rac_pkg::MAC_STATUS_OFS, 32'h0000_0000, r);
         check(r, {12'h000, exp[i], 16'h0000}, rac_pkg::MAC_STATUS_STKY);
      end
   endtask : t_sticky

   task automatic t_sc;
      logic [31:0] r;
      acc(1'b1, rac_pkg::SYS_CTRL_OFS, 32'h0000_1000, r);
      acc(1'b1, rac_pkg::MAC_CTRL_OFS, 32'h0001_0000, r);
      @(negedge REF_CLK);
      check(MAC_CTRL_Q, 32'h0001_0000, rac_pkg::MAC_CTRL_SC);
      @(negedge REF_CLK);
      check(MAC_CTRL_Q, 32'h0000_0000, rac_pkg::MAC_CTRL_SC);
      acc(1'b0, rac_pkg::SYS_CTRL_OFS, 32'h0000_0000, r);
      check(r, 32'h0000_0000, rac_pkg::SYS_CTRL_SC);
   endtask : t_sc

   // soft reset spares immune bits, hard reset does not
   task automatic t_soft;
      logic [31:0] r;
      acc(1'b1, rac_pkg::SYS_CTRL_OFS, 32'h00AB_20C3, r);
      acc(1'b1, rac_pkg::MAC_CTRL_OFS, 32'h0000_5A00, r);
      check(SYS_CTRL_Q, 32'h00AB_20C3, ~rac_pkg::SYS_CTRL_RSVD);
      @(posedge REF_CLK);
      SOFT_RST <= 1'b1;
      @(posedge REF_CLK);
      SOFT_RST <= 1'b0;
      repeat (2) @(negedge REF_CLK);
      check(SYS_CTRL_Q, 32'h0000_00C3, ~rac_pkg::SYS_CTRL_RSVD);
      check(MAC_CTRL_Q, 32'h0000_5A00, ~rac_pkg::MAC_CTRL_RSVD);
      @(posedge REF_CLK);
      RST <= 1'b1;
      @(posedge REF_CLK);
      RST <= 1'b0;
      @(negedge REF_CLK);
      check(SYS_CTRL_Q | MAC_CTRL_Q, 32'h0000_0000, 32'h0000_FFFF);
   endtask : t_soft

   // ---------------------------------------------------------------
   // run control
   // ---------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report

   // hang guard
   always @(posedge REF_CLK) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         fail_count++;
         final_report();
      end
   end

   // main sequence
   initial begin
      RST          = 1'b1;
      SOFT_RST     = 1'b0;
      ACC_REQ      = 1'b0;
      ACC_WR       = 1'b0;
      ACC_ADDR     = 9'h000;
      ACC_WDATA    = 32'h0000_0000;
      SYS_STAT_VAL = 32'h000F_0000;
      SYS_STAT_SET = 32'h0000_0000;
      SYS_EVT_SET  = 32'h0000_0000;
      MAC_STAT_VAL = 32'h0000_0000;
      MAC_STAT_SET = 32'h0000_0000;
      repeat (3) @(posedge REF_CLK);
      RST <= 1'b0;
      t_map();
      t_ro();
      t_rs();
      t_evt();
      t_rc();
      t_sticky();
      t_sc();
      t_soft();
      final_report();
   end
endmodule : tb

`default_nettype wire
